// >>> src/remote_ground_closure_control.sv
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module remote_ground_closure_control
   import rgc_pkg::*;
#(
   parameter int STABLE = STABLE_SAMPLES
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic own_remote_n,
   input wire logic own_serial_n,
   input wire logic reset_req_n,
   input wire logic route_n,
   input wire logic genlock_n,
   input wire logic vir_mode_n,
   input wire logic dac_src_n,
   input wire logic field1_enter_n,
   input wire logic field2_enter_n,
   input wire logic [3:0] ff_code_n,
   input wire logic [2:0] line_code_n,
   input wire logic [3:0] vit_code_n,
   output logic [1:0] owner,
   output logic bypass_relay,
   output logic genlock_ref,
   output logic [3:0] ff_signal,
   output logic vertical_interval_reference_insert,
   output logic dac_src,
   output logic defaults_load,
   output logic vertical_interval_test_insert,
   output logic [4:0] insert_line,
   output logic [1:0] insert_field,
   output logic [3:0] insert_signal
);
   localparam int TW = $clog2(SAMPLE_CYC + 1);

   if (SAMPLE_CYC < 1) $error("sample period shorter than one clock");

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [TW-1:0] tcnt;     // sample divider
      logic tick;              // one-cycle sample enable
      logic [1:0] owner;       // current control owner
      logic bypass;            // relay closed
      logic genlock;           // 1 = reference burst input
      logic vir;               // reference insertion mode
      logic dac;               // converter data source
      logic [3:0] ff_sig;      // selected full-field signal
      logic [3:0] dflt_ff;     // saved default full-field signal
      logic dflt_vir;          // saved default reference mode
      logic [3:0] tbl_idx;     // map entry reached by the bus
      logic rst_prev;          // last settled reset line
      logic [1:0] ent_prev;    // last settled field enter lines
      logic ins_wr;            // nonvolatile write strobe
      logic [4:0] ins_line;
      logic [1:0] ins_field;
      logic [3:0] ins_sig;
      logic dload;             // defaults restored strobe
      logic wait_n;            // 0 while waitrequest is high
      logic [31:0] rdata;
   } top_s;

   top_s st_ff;
   top_s nxt_st;

   pin_level_if #(.W(PIN_W)) lv ();
   logic [PIN_W-1:0] pins;    // raw pins in filter order
   logic [3:0] map;           // map output for the settled code
   logic [3:0] tbl_rd;        // map entry at the bus index
   logic tbl_wr;              // bus write to the map
   logic req;                 // bus request present
   logic acc;                 // request completes this edge
   logic rst_evt;             // reset line just grounded
   logic [1:0] ent_evt;       // enter lines just grounded
   logic is_remote;           // remote port owns control
   logic [31:0] rd_mux;

   assign pins = {vit_code_n, line_code_n, ff_code_n, field2_enter_n, field1_enter_n, dac_src_n,
                  vir_mode_n, genlock_n, route_n, reset_req_n, own_serial_n, own_remote_n};

   // ----------------------------------------------------------------
   // pin conditioning and code map
   // ----------------------------------------------------------------
   pin_filter #(.W(PIN_W), .STABLE(STABLE)) u_filter (
      .mclk (mclk),
      .rst (rst),
      .tick (st_ff.tick),
      .pins (pins),
      .lv (lv.src)
   );

   ff_map_table u_map (
      .mclk (mclk),
      .rst (rst),
      .wr_en (tbl_wr),
      .wr_idx (st_ff.tbl_idx),
      .wr_data (avs_writedata[3:0]),
      .code (lv.level[P_FF +: 4]),
      .map (map)
   );

   ff_map_table u_map_rd (
      .mclk (mclk),
      .rst (rst),
      .wr_en (tbl_wr),
      .wr_idx (st_ff.tbl_idx),
      .wr_data (avs_writedata[3:0]),
      .code (st_ff.tbl_idx),
      .map (tbl_rd)
   );

   // ----------------------------------------------------------------
   // events and bus decode
   // ----------------------------------------------------------------
   // a grounded line means asserted
   assign rst_evt = st_ff.rst_prev && !lv.level[P_RESET];
   assign ent_evt = st_ff.ent_prev & ~lv.level[P_F2:P_F1];
   assign is_remote = (st_ff.owner == OWN_REMOTE);
   assign req = avs_read || avs_write;
   assign acc = req && st_ff.wait_n;
   assign tbl_wr = acc && avs_write && (avs_address == REG_TBL_DATA);

   // register read mux; unmapped offsets read zero
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (avs_address == REG_STATUS)
      begin
         rd_mux[ST_OWNER +: 2] = st_ff.owner;
         rd_mux[ST_BYPASS] = st_ff.bypass;
         rd_mux[ST_GENLOCK] = st_ff.genlock;
         rd_mux[ST_VIR] = st_ff.vir;
         rd_mux[ST_DAC] = st_ff.dac;
         rd_mux[ST_FF +: 4] = st_ff.ff_sig;
      end
      else if (avs_address == REG_DEFAULT)
      begin
         rd_mux[DF_FF +: 4] = st_ff.dflt_ff;
         rd_mux[DF_VIR] = st_ff.dflt_vir;
      end
      else if (avs_address == REG_TBL_IDX)
      begin
         rd_mux[3:0] = st_ff.tbl_idx;
      end
      else if (avs_address == REG_TBL_DATA)
      begin
         rd_mux[3:0] = tbl_rd;
      end
      else if (avs_address == REG_INSERT)
      begin
         rd_mux[IN_LINE +: 5] = st_ff.ins_line;
         rd_mux[IN_FIELD +: 2] = st_ff.ins_field;
         rd_mux[IN_SIG +: 4] = st_ff.ins_sig;
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.ins_wr = 1'b0;
      nxt_st.dload = 1'b0;
      // sample divider
      nxt_st.tick = 1'b0;
      if (st_ff.tcnt >= TW'(SAMPLE_CYC - 1))
      begin
         nxt_st.tcnt = '0;
         nxt_st.tick = 1'b1;
      end
      else
      begin
         nxt_st.tcnt = TW'(st_ff.tcnt + TW'(1));
      end
      // ownership follows the lines every cycle, nothing kept
      if (!lv.level[P_OWN_REM] && lv.level[P_OWN_SER])
      begin
         nxt_st.owner = OWN_REMOTE;
      end
      else if (lv.level[P_OWN_REM] && !lv.level[P_OWN_SER])
      begin
         nxt_st.owner = OWN_SERIAL;
      end
      else
      begin
         // both grounded is not defined; front panel is the safe owner
         nxt_st.owner = OWN_FRONT;
      end
      // these act whatever the owner
      nxt_st.genlock = !lv.level[P_GENLOCK];
      // locking to the reference burst also bypasses the program path
      nxt_st.bypass = !lv.level[P_ROUTE] || !lv.level[P_GENLOCK];
      nxt_st.dac = !lv.level[P_DAC];
      nxt_st.rst_prev = lv.level[P_RESET];
      nxt_st.ent_prev = lv.level[P_F2:P_F1];
      // remote-only selections
      if (is_remote)
      begin
         nxt_st.vir = !lv.level[P_VIR];
         if (map != FF_NOCHG)
         begin
            nxt_st.ff_sig = map;
         end
         if (ent_evt != 2'b00)
         begin
            // one strobe per enter; both grounded programs both fields
            nxt_st.ins_wr = 1'b1;
            nxt_st.ins_line = LINE_BASE + {2'b00, lv.level[P_LINE +: 3]};
            nxt_st.ins_field = ent_evt;
            nxt_st.ins_sig = lv.level[P_VIT +: 4];
         end
      end
      // reset request wins over a remote selection in the same cycle
      if (rst_evt)
      begin
         nxt_st.ff_sig = st_ff.dflt_ff;
         nxt_st.vir = st_ff.dflt_vir;
         nxt_st.dload = 1'b1;
      end
      // bus slave: one wait cycle, then complete
      nxt_st.wait_n = req && !st_ff.wait_n;
      if (req && !st_ff.wait_n && avs_read)
      begin
         nxt_st.rdata = rd_mux;
      end
      if (acc && avs_write)
      begin
         if (avs_address == REG_DEFAULT)
         begin
            nxt_st.dflt_ff = avs_writedata[DF_FF +: 4];
            nxt_st.dflt_vir = avs_writedata[DF_VIR];
         end
         else if (avs_address == REG_TBL_IDX)
         begin
            nxt_st.tbl_idx = avs_writedata[3:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         st_ff <= '{tcnt: '0, tick: 1'b0, owner: OWN_FRONT, bypass: 1'b0, genlock: 1'b0, vir: DFLT_VIR_RST,
                    dac: 1'b0, ff_sig: DFLT_FF_RST, dflt_ff: DFLT_FF_RST, dflt_vir: DFLT_VIR_RST,
                    tbl_idx: 4'h0, rst_prev: 1'b1, ent_prev: 2'b11, ins_wr: 1'b0, ins_line: LINE_BASE,
                    ins_field: 2'b00, ins_sig: 4'hF, dload: 1'b0, wait_n: 1'b0, rdata: 32'h0000_0000};
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs, all straight from the state register
   // ----------------------------------------------------------------
   assign avs_readdata = st_ff.rdata;
   assign avs_waitrequest = !st_ff.wait_n;
   assign owner = st_ff.owner;
   assign bypass_relay = st_ff.bypass;
   assign genlock_ref = st_ff.genlock;
   assign ff_signal = st_ff.ff_sig;
   assign vertical_interval_reference_insert = st_ff.vir;
   assign dac_src = st_ff.dac;
   assign defaults_load = st_ff.dload;
   assign vertical_interval_test_insert = st_ff.ins_wr;
   assign insert_line = st_ff.ins_line;
   assign insert_field = st_ff.ins_field;
   assign insert_signal = st_ff.ins_sig;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_BYPASS_ON_GROUND: assert property (@(posedge mclk) disable iff (rst)
      !lv.level[P_ROUTE] |=> bypass_relay) else $error("routing line grounded but relay open");
   AST_GENLOCK_REF: assert property (@(posedge mclk) disable iff (rst)
      !lv.level[P_GENLOCK] |=> genlock_ref && bypass_relay) else $error("reference genlock not taken");
   AST_OWNER_REMOTE: assert property (@(posedge mclk) disable iff (rst)
      (!lv.level[P_OWN_REM] && lv.level[P_OWN_SER]) |=> owner == OWN_REMOTE) else $error("remote not owner");
   AST_OWNER_FRONT: assert property (@(posedge mclk) disable iff (rst)
      (lv.level[P_OWN_REM] && lv.level[P_OWN_SER]) |=> owner == OWN_FRONT) else $error("front not owner");
   AST_FF_NEEDS_REMOTE: assert property (@(posedge mclk) disable iff (rst)
      (!is_remote && !rst_evt) |=> $stable(ff_signal)) else $error("full field changed without remote owner");
   AST_FF_BARS: assert property (@(posedge mclk) disable iff (rst)
      (is_remote && !rst_evt && lv.level[P_FF +: 4] == 4'h7 && map == FF_BARS) |=> ff_signal == FF_BARS)
      else $error("code 0111 did not select bars");
   AST_INSERT_LINE: assert property (@(posedge mclk) disable iff (rst)
      (is_remote && ent_evt != 2'b00) |=> vertical_interval_test_insert
      && insert_line == LINE_BASE + {2'b00, $past(lv.level[P_LINE +: 3])} && insert_line <= 5'h15)
      else $error("insertion line not code plus fourteen");
   AST_NV_ONLY_REMOTE: assert property (@(posedge mclk) disable iff (rst)
      vertical_interval_test_insert |-> $past(is_remote) ##1 !vertical_interval_test_insert)
      else $error("nonvolatile write without remote owner or held");
   AST_RESET_DEFAULTS: assert property (@(posedge mclk) disable iff (rst)
      rst_evt |=> defaults_load && ff_signal == $past(st_ff.dflt_ff)) else $error("defaults not restored");
   AST_BUS_ONE_WAIT: assert property (@(posedge mclk) disable iff (rst)
      (req && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer not one wait");

endmodule : remote_ground_closure_control

// >>> src/rgc_pkg.sv
package rgc_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_NS = 100;                     // mclk period
   localparam int SAMPLE_NS = 100000;               // pin sampling period, 100 us
   localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int STABLE_SAMPLES = 4;               // equal samples before a code counts

   // ----------------------------------------------------------------
   // filtered pin vector layout (value 0 = grounded)
   // ----------------------------------------------------------------
   localparam int P_OWN_REM = 0;
   localparam int P_OWN_SER = 1;
   localparam int P_RESET = 2;
   localparam int P_ROUTE = 3;
   localparam int P_GENLOCK = 4;
   localparam int P_VIR = 5;
   localparam int P_DAC = 6;
   localparam int P_F1 = 7;
   localparam int P_F2 = 8;
   localparam int P_FF = 9;                         // 4 bits
   localparam int P_LINE = 13;                      // 3 bits
   localparam int P_VIT = 16;                       // 4 bits
   localparam int PIN_W = 20;

   // ----------------------------------------------------------------
   // selections
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {OWN_FRONT, OWN_REMOTE, OWN_SERIAL} owner_e;
   localparam logic [4:0] LINE_BASE = 5'h0E;        // code 000 is line 14
   localparam logic [3:0] FF_NOCHG = 4'h0;          // table value meaning hold
   localparam logic [3:0] FF_BARS = 4'h8;           // colour bars
   // shipped code-to-signal map, index 15 in the top nibble
   localparam logic [15:0][3:0] FF_FACTORY_MAP = 64'h0123_4567_809A_BCD0;

   // ----------------------------------------------------------------
   // register map (byte addresses) and fields
   // ----------------------------------------------------------------
   localparam logic [5:0] REG_STATUS = 6'h00;
   localparam logic [5:0] REG_DEFAULT = 6'h04;
   localparam logic [5:0] REG_TBL_IDX = 6'h08;
   localparam logic [5:0] REG_TBL_DATA = 6'h0C;
   localparam logic [5:0] REG_INSERT = 6'h10;
   localparam int ST_OWNER = 0;                     // 2 bits
   localparam int ST_BYPASS = 2;
   localparam int ST_GENLOCK = 3;
   localparam int ST_VIR = 4;
   localparam int ST_DAC = 5;
   localparam int ST_FF = 8;                        // 4 bits
   localparam int DF_FF = 0;                        // 4 bits
   localparam int DF_VIR = 4;
   localparam int IN_LINE = 0;                      // 5 bits
   localparam int IN_FIELD = 8;                     // 2 bits
   localparam int IN_SIG = 12;                      // 4 bits
   localparam logic [3:0] DFLT_FF_RST = FF_BARS;
   localparam logic DFLT_VIR_RST = 1'b0;

endpackage : rgc_pkg

// >>> src/pin_level_if.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// settled pin levels from the filter to the decoder
// ----------------------------------------------------------------
interface pin_level_if #(parameter int W = 20);
   logic [W-1:0] level;   // settled levels, 0 = grounded
   modport src (output level);
   modport dst (input level);
endinterface : pin_level_if

// >>> src/pin_filter.sv
`timescale 1ns/10ps
module pin_filter
   import rgc_pkg::*;
#(
   parameter int W = PIN_W,
   parameter int STABLE = STABLE_SAMPLES
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic tick,
   input wire logic [W-1:0] pins,
   pin_level_if.src lv
);
   localparam int CW = $clog2(STABLE + 1);

   if (STABLE < 1) $error("pin_filter needs at least one stable sample");

   typedef struct packed {
      logic [W-1:0] s1;     // first stage, read only by s2
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] cand;   // code being watched
      logic [CW-1:0] cnt;   // equal samples seen so far
      logic [W-1:0] level;  // accepted code
   } filt_s;

   filt_s st_ff;
   filt_s nxt_st;

   // ----------------------------------------------------------------
   // sample, then accept only a code that holds for STABLE+1 ticks
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.s1 = pins;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      if (tick && (st_ff.s2 == st_ff.s3))
      begin
         // long cables slew slowly, so a code mid-change is not trusted
         if (st_ff.s3 != st_ff.cand)
         begin
            nxt_st.cand = st_ff.s3;
            nxt_st.cnt = CW'(1);
         end
         else if (st_ff.cnt >= CW'(STABLE))
         begin
            nxt_st.level = st_ff.cand;
         end
         else
         begin
            nxt_st.cnt = CW'(st_ff.cnt + CW'(1));
         end
      end
   end

   // open lines read high, so samples, candidate and level reset to all ones; the count resets to zero
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         st_ff <= '{s1: '1, s2: '1, s3: '1, cand: '1, cnt: '0, level: '1};
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign lv.level = st_ff.level;

   AST_LEVEL_ON_TICK: assert property (@(posedge mclk) disable iff (rst) !tick |=> $stable(st_ff.level))
      else $error("settled level moved without a sample tick");

endmodule : pin_filter

// >>> src/ff_map_table.sv
`timescale 1ns/10ps
module ff_map_table
   import rgc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [3:0] wr_idx,
   input wire logic [3:0] wr_data,
   input wire logic [3:0] code,
   output logic [3:0] map
);
   typedef struct packed {
      logic [15:0][3:0] ent;   // signal number for each remote code
   } tbl_s;

   tbl_s st_ff;
   tbl_s nxt_st;

   // ----------------------------------------------------------------
   // rewritable code map, loaded with the shipped map at reset
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_st = st_ff;
      if (wr_en)
      begin
         nxt_st.ent[wr_idx] = wr_data;
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         st_ff.ent <= FF_FACTORY_MAP;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign map = st_ff.ent[code];

endmodule : ff_map_table

// >>> dv/remote_panel.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// remote switch panel: a closed switch grounds its port line
// ----------------------------------------------------------------
module remote_panel
   import rgc_pkg::*;
(
   input wire logic [PIN_W-1:0] gnd,   // closed switches, one per line
   output logic [PIN_W-1:0] level      // levels seen at the port
);
   // an open line rests at its pull-up, so it never holds a stale 0
   assign level = ~gnd;
endmodule : remote_panel

// >>> dv/remote_ground_closure_control_tb.sv
`timescale 1ns/10ps
// one compare: counts it, reports a mismatch at once
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
   $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module remote_ground_closure_control_tb
   import rgc_pkg::*;
;
   // ----------------------------------------------------------------
   // set-up
   // ----------------------------------------------------------------
   localparam int STB = 1;                              // short filter keeps the run small
   localparam int SETTLE = (STB + 2) * SAMPLE_CYC + 10; // worst pin-to-output delay
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [PIN_W-1:0] gnd = '0;                          // all switches open
   logic [PIN_W-1:0] lv;
   logic [1:0] owner;
   logic bypass_relay, genlock_ref, vir, dac_src, defaults_load, vit;
   logic [3:0] ff_signal, insert_signal;
   logic [4:0] insert_line;
   logic [1:0] insert_field;
   int errors = 0;
   int tests_run = 0;
   int n_ld = 0;                                        // defaults-load pulses seen
   int n_ins = 0;                                       // nonvolatile write pulses seen
   always #50 mclk = ~mclk;
   remote_panel remote_panel_i (.gnd(gnd), .level(lv));
   remote_ground_closure_control #(.STABLE(STB)) remote_ground_closure_control_i (
      .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .own_remote_n(lv[P_OWN_REM]), .own_serial_n(lv[P_OWN_SER]),
      .reset_req_n(lv[P_RESET]), .route_n(lv[P_ROUTE]), .genlock_n(lv[P_GENLOCK]),
      .vir_mode_n(lv[P_VIR]), .dac_src_n(lv[P_DAC]), .field1_enter_n(lv[P_F1]),
      .field2_enter_n(lv[P_F2]), .ff_code_n(lv[P_FF +: 4]), .line_code_n(lv[P_LINE +: 3]),
      .vit_code_n(lv[P_VIT +: 4]), .owner(owner), .bypass_relay(bypass_relay),
      .genlock_ref(genlock_ref), .ff_signal(ff_signal), .vertical_interval_reference_insert(vir),
      .dac_src(dac_src), .defaults_load(defaults_load), .vertical_interval_test_insert(vit),
      .insert_line(insert_line), .insert_field(insert_field), .insert_signal(insert_signal));
   // pulses last one cycle, so they are counted rather than polled
   always @(posedge mclk)
   begin
      if (defaults_load === 1'b1) n_ld++;
      if (vit === 1'b1) n_ins++;
   end
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   // one bus access, held until waitrequest is seen low; only the watchdog bounds the wait
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge mclk);
      avs_read <= ~wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   // read and compare under a mask of the bits that matter
   task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      `CHK(q & m, e)
   endtask : rd
   // singles in pin order, codes as printed (0 = grounded)
   task automatic panel(input logic [8:0] s, input logic [3:0] ff, input logic [2:0] ln, input logic [3:0] vt);
      @(posedge mclk);
      gnd <= {~vt, ~ln, ~ff, s};
      repeat (SETTLE) @(posedge mclk);
   endtask : panel
   task test_done;
      if (errors == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : test_done
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   initial
   begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      rd(REG_STATUS, ALL, 32'h0000_0800);
      rd(REG_INSERT, ALL, 32'h0000_F00E);
      wr(6'h14, ALL);
      rd(6'h14, ALL, 32'h0);
      wr(REG_DEFAULT, 32'h0000_0015);
      rd(REG_DEFAULT, ALL, 32'h0000_0015);
      wr(REG_TBL_IDX, 32'h0000_0007);
      rd(REG_TBL_DATA, ALL, 32'h0000_0008);
      wr(REG_TBL_IDX, 32'h0000_000E);
      wr(REG_TBL_DATA, 32'h0000_0003);
      rd(REG_TBL_DATA, ALL, 32'h0000_0003);
      rd(REG_TBL_IDX, ALL, 32'h0000_000E);
      // a short glitch must not reach the relay
      @(posedge mclk);
      gnd <= 20'h0_0008;
      repeat (500) @(posedge mclk);
      panel(9'h000, 4'hF, 3'h7, 4'hF);
      `CHK(bypass_relay, 1'b0)
      panel(9'h068, 4'h5, 3'h7, 4'hF);
      rd(REG_STATUS, ALL, 32'h0000_0824);
      `CHK({vir, dac_src}, 2'b01)
      panel(9'h070, 4'h5, 3'h7, 4'hF);
      rd(REG_STATUS, ALL, 32'h0000_082C);
      `CHK(genlock_ref, 1'b1)
      panel(9'h061, 4'h5, 3'h7, 4'hF);
      rd(REG_STATUS, ALL, 32'h0000_0931);
      `CHK({owner, vir, dac_src}, 4'b0111)
      panel(9'h061, 4'hE, 3'h7, 4'hF);
      `CHK(ff_signal, 4'h3)
      panel(9'h061, 4'hF, 3'h7, 4'hF);
      `CHK(ff_signal, 4'h3)
      panel(9'h0E1, 4'h7, 3'h3, 4'hC);
      `CHK(ff_signal, 4'h8)
      `CHK(n_ins, 1)
      rd(REG_INSERT, ALL, 32'h0000_C111);
      panel(9'h061, 4'h7, 3'h7, 4'hC);
      panel(9'h1E1, 4'h7, 3'h7, 4'hC);
      `CHK(n_ins, 2)
      `CHK({insert_signal, insert_field, insert_line}, 11'h675)
      panel(9'h063, 4'h7, 3'h7, 4'hF);
      rd(REG_STATUS, 32'h0000_0003, 32'h0);
      panel(9'h0E2, 4'h5, 3'h7, 4'hF);
      rd(REG_STATUS, 32'h0000_0F03, 32'h0000_0802);
      `CHK(n_ins, 2)
      panel(9'h004, 4'hF, 3'h7, 4'hF);
      `CHK(n_ld, 1)
      rd(REG_STATUS, ALL, 32'h0000_0510);
      panel(9'h000, 4'hF, 3'h7, 4'hF);
      `CHK(n_ld, 1)
      test_done;
   end
   // watchdog: the sequence needs about 40000 cycles
   initial
   begin
      repeat (70000) @(posedge mclk);
      errors++;
      test_done;
   end
endmodule : remote_ground_closure_control_tb
